//--- core/lsma_defines.svh
// Constants for the load/store memory access block.
`ifndef LSMA_DEFINES_SVH
`define LSMA_DEFINES_SVH
`define LSMA_SZ_BYTE 3'h0
`define LSMA_SZ_HALF 3'h1
`define LSMA_SZ_WORD 3'h3
`define LSMA_SZ_DOUBLE 3'h7
`define LSMA_UNMAP_LO 3'h4
`define LSMA_UNMAP_HI 3'h5
`define LSMA_CCA_UNCACHED 3'h2
`define LSMA_CCA_CACHED 3'h3
`define LSMA_FILL_BEATS 4'h4
`endif

//--- core/lsma_pkg.sv
// Types shared by the load/store memory access block.
package lsma_pkg;
    typedef enum logic [2:0] {
        LSMA_OP_LOAD = 3'h0,
        LSMA_OP_STORE = 3'h1,
        LSMA_OP_COPROC_WORD_LOAD = 3'h2,
        LSMA_OP_COPROC_DOUBLE_LOAD = 3'h3,
        LSMA_OP_COPROC_WORD_STORE = 3'h4,
        LSMA_OP_COPROC_DOUBLE_STORE = 3'h5,
        LSMA_OP_COP_FN = 3'h6
    } lsma_op_t;
    typedef struct packed {
        lsma_op_t op;
        logic [31:0] virtual_addr;
        logic [2:0] access_size_code;
        logic fetch_or_data_sel;
        logic big_endian;
        logic [63:0] wdata;
        logic [1:0] coproc_unit;
        logic [4:0] coproc_reg_select;
        logic [24:0] cop_fun;
    } lsma_req_t;
    typedef struct packed {
        logic [31:0] phys_addr;
        logic [2:0] cache_coherency_attr;
        logic load_or_store_sel;
        logic fetch_or_data_sel;
    } lsma_xlat_t;
    typedef struct packed {
        logic [31:0] addr;
        logic [2:0] cache_coherency_attr;
        logic write;
        logic [7:0] byte_strobe;
        logic [63:0] memory_element;
    } lsma_mem_req_t;
    typedef struct packed {
        lsma_op_t op;
        logic [1:0] unit;
        logic [4:0] coproc_reg_select;
        logic [24:0] cop_fun;
        logic [63:0] data;
    } lsma_cop_t;
    typedef enum logic [2:0] {
        LSMA_ST_IDLE = 3'h0,
        LSMA_ST_XLAT = 3'h1,
        LSMA_ST_COPRD = 3'h2,
        LSMA_ST_MEM = 3'h3,
        LSMA_ST_DONE = 3'h4
    } lsma_state_t;
endpackage : lsma_pkg

//--- core/lsma_core.sv
// Load/store access: translation, byte lane select, memory and coprocessors.
`timescale 1ns/1ps
`default_nettype none
`include "lsma_defines.svh"
module lsma_core #(
    parameter int ELEM_BYTES = 8
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic req_valid,
    output logic req_ready,
    input wire lsma_pkg::lsma_req_t req,
    output logic xlat_valid,
    output lsma_pkg::lsma_xlat_t xlat_req,
    input wire logic xlat_done,
    input wire logic xlat_hit,
    input wire logic xlat_permit,
    input wire logic [31:0] xlat_phys_addr,
    input wire logic [2:0] xlat_cca,
    output logic mem_valid,
    output lsma_pkg::lsma_mem_req_t mem_req,
    input wire logic mem_ready,
    input wire logic mem_rvalid,
    input wire logic cache_miss,
    input wire logic [63:0] mem_rdata,
    output logic fill_valid,
    output logic [31:0] fill_addr,
    output logic cop_valid,
    output lsma_pkg::lsma_cop_t cop_out,
    input wire logic cop_ready,
    input wire logic [63:0] cop_sdata,
    output logic done_valid,
    output logic [63:0] load_data,
    output logic [7:0] load_valid_bytes,
    output logic exc_valid
);
    localparam int AW = $clog2(ELEM_BYTES);

    lsma_pkg::lsma_state_t state_ff;
    lsma_pkg::lsma_req_t req_ff;
    lsma_pkg::lsma_xlat_t xl_ff;
    lsma_pkg::lsma_mem_req_t mem_ff;
    lsma_pkg::lsma_cop_t cop_ff;
    logic [63:0] load_data_ff;
    logic [7:0] lvb_ff;
    logic exc_ff;

    // Lane mask from size code and low address bits; lowest address names
    // the object, so lanes run upward from the offset, mirrored for big-endian.
    function automatic logic [7:0] lane_mask(input logic [2:0] sz,
                                             input logic [2:0] lo,
                                             input logic be);
        logic [7:0] m;
        logic [3:0] n;
        logic [2:0] off;
        m = 8'h00;
        n = {1'b0, sz} + 4'h1;
        off = (AW == 3) ? lo : {1'b0, lo[1:0]};
        for (int i = 0; i < 8; i++) begin
            if (i < ELEM_BYTES && 4'(i) >= {1'b0, off} &&
                4'(i) < {1'b0, off} + n) begin
                m[i] = 1'b1;
            end
        end
        // Big-endian mirrors byte lanes inside the element.
        if (be) begin
            logic [7:0] r;
            r = 8'h00;
            for (int i = 0; i < 8; i++) begin
                if (i < ELEM_BYTES) begin
                    r[ELEM_BYTES - 1 - i] = m[i];
                end
            end
            m = r;
        end
        return m;
    endfunction : lane_mask

    // Place or extract data so the addressed byte holds MSB (big) or LSB.
    function automatic logic [63:0] lane_shift(input logic [63:0] d,
                                               input logic [2:0] sz,
                                               input logic [2:0] lo,
                                               input logic be,
                                               input logic to_mem);
        logic [2:0] off;
        logic [5:0] sh;
        off = (AW == 3) ? lo : {1'b0, lo[1:0]};
        if (be) begin
            sh = 6'((ELEM_BYTES - 1 - int'(off) - int'(sz)) * 8);
        end else begin
            sh = 6'(int'(off) * 8);
        end
        return to_mem ? (d << sh) : (d >> sh);
    endfunction : lane_shift

    function automatic logic [63:0] store_src(input lsma_pkg::lsma_req_t r,
                                              input logic [63:0] cd);
        unique case (r.op)
            lsma_pkg::LSMA_OP_COPROC_WORD_STORE: return {32'h0, cd[31:0]};
            lsma_pkg::LSMA_OP_COPROC_DOUBLE_STORE: return cd;
            default: return r.wdata;
        endcase
    endfunction : store_src

    logic is_store;
    logic is_cop_st;
    logic unmapped;
    logic [7:0] strobe;
    logic [31:0] pa_now;
    logic [2:0] cca_now;
    // The element request is loaded on the edge that leaves translation,
    // so it must see the address being resolved now, not the stale copy.
    assign pa_now = state_ff != lsma_pkg::LSMA_ST_XLAT ? xl_ff.phys_addr :
                    unmapped ? {3'h0, req_ff.virtual_addr[28:0]} :
                    xlat_phys_addr;
    assign cca_now = state_ff != lsma_pkg::LSMA_ST_XLAT ?
                     xl_ff.cache_coherency_attr :
                     unmapped ? (req_ff.virtual_addr[29] ? `LSMA_CCA_UNCACHED
                                 : `LSMA_CCA_CACHED) : xlat_cca;
    assign is_store = req_ff.op inside {lsma_pkg::LSMA_OP_STORE,
                                         lsma_pkg::LSMA_OP_COPROC_WORD_STORE,
                                         lsma_pkg::LSMA_OP_COPROC_DOUBLE_STORE};
    assign is_cop_st = req_ff.op inside {lsma_pkg::LSMA_OP_COPROC_WORD_STORE,
                                          lsma_pkg::LSMA_OP_COPROC_DOUBLE_STORE};
    assign unmapped = req_ff.virtual_addr[31:29] == `LSMA_UNMAP_LO ||
                      req_ff.virtual_addr[31:29] == `LSMA_UNMAP_HI;
    assign strobe = lane_mask(req_ff.access_size_code,
                              pa_now[2:0], req_ff.big_endian);

    assign req_ready = state_ff == lsma_pkg::LSMA_ST_IDLE;
    assign xlat_valid = state_ff == lsma_pkg::LSMA_ST_XLAT && !unmapped &&
                        req_ff.op != lsma_pkg::LSMA_OP_COP_FN;
    assign xlat_req = xl_ff;
    assign mem_valid = state_ff == lsma_pkg::LSMA_ST_MEM;
    assign mem_req = mem_ff;
    assign cop_valid = state_ff == lsma_pkg::LSMA_ST_COPRD ||
                       (state_ff == lsma_pkg::LSMA_ST_DONE &&
                        cop_ff.op != lsma_pkg::LSMA_OP_LOAD);
    assign cop_out = cop_ff;
    assign done_valid = state_ff == lsma_pkg::LSMA_ST_DONE &&
                        (!cop_valid || cop_ready);
    assign load_data = load_data_ff;
    assign load_valid_bytes = lvb_ff;
    assign exc_valid = exc_ff;
    assign fill_valid = mem_valid && mem_rvalid && cache_miss &&
                        !mem_ff.write &&
                        mem_ff.cache_coherency_attr == `LSMA_CCA_CACHED;
    // Fill block is the whole aligned element at least.
    assign fill_addr = {mem_ff.addr[31:AW], AW'(0)};

    // One step at a time keeps each step's effects in program order.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_ff <= lsma_pkg::LSMA_ST_IDLE;
        end else begin
            unique case (state_ff)
                lsma_pkg::LSMA_ST_IDLE: if (req_valid) begin
                    state_ff <= lsma_pkg::LSMA_ST_XLAT;
                end
                lsma_pkg::LSMA_ST_XLAT: begin
                    if (req_ff.op == lsma_pkg::LSMA_OP_COP_FN) begin
                        state_ff <= lsma_pkg::LSMA_ST_DONE;
                    end else if (unmapped) begin
                        state_ff <= is_cop_st ? lsma_pkg::LSMA_ST_COPRD
                                              : lsma_pkg::LSMA_ST_MEM;
                    end else if (xlat_done) begin
                        if (!xlat_hit || !xlat_permit) begin
                            state_ff <= lsma_pkg::LSMA_ST_DONE;
                        end else begin
                            state_ff <= is_cop_st ? lsma_pkg::LSMA_ST_COPRD
                                                  : lsma_pkg::LSMA_ST_MEM;
                        end
                    end
                end
                lsma_pkg::LSMA_ST_COPRD: if (cop_ready) begin
                    state_ff <= lsma_pkg::LSMA_ST_MEM;
                end
                lsma_pkg::LSMA_ST_MEM: begin
                    if (mem_ready && (mem_ff.write || mem_rvalid)) begin
                        state_ff <= lsma_pkg::LSMA_ST_DONE;
                    end
                end
                lsma_pkg::LSMA_ST_DONE: if (done_valid) begin
                    state_ff <= lsma_pkg::LSMA_ST_IDLE;
                end
                default: state_ff <= lsma_pkg::LSMA_ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            req_ff <= '0;
            xl_ff <= '0;
        end else if (state_ff == lsma_pkg::LSMA_ST_IDLE && req_valid) begin
            req_ff <= req;
            xl_ff.phys_addr <= req.virtual_addr;
            xl_ff.cache_coherency_attr <= `LSMA_CCA_UNCACHED;
            xl_ff.fetch_or_data_sel <= req.fetch_or_data_sel;
            xl_ff.load_or_store_sel <= req.op inside {
                lsma_pkg::LSMA_OP_STORE, lsma_pkg::LSMA_OP_COPROC_WORD_STORE,
                lsma_pkg::LSMA_OP_COPROC_DOUBLE_STORE};
        end else if (state_ff == lsma_pkg::LSMA_ST_XLAT) begin
            if (unmapped) begin
                // Lowest segment bit (bit 29) picks cacheability, low bits map flat.
                xl_ff.phys_addr <= {3'h0, req_ff.virtual_addr[28:0]};
                xl_ff.cache_coherency_attr <= req_ff.virtual_addr[29] ?
                    `LSMA_CCA_UNCACHED : `LSMA_CCA_CACHED;
            end else if (xlat_done) begin
                xl_ff.phys_addr <= xlat_phys_addr;
                xl_ff.cache_coherency_attr <= xlat_cca;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            mem_ff <= '0;
        end else if (state_ff == lsma_pkg::LSMA_ST_COPRD ||
                     (state_ff == lsma_pkg::LSMA_ST_XLAT && !is_cop_st)) begin
            // Element address is aligned; lanes carry the offset.
            mem_ff.addr <= {pa_now[31:AW], AW'(0)};
            mem_ff.cache_coherency_attr <= cca_now;
            mem_ff.write <= is_store;
            mem_ff.byte_strobe <= strobe;
            // Unselected lanes are zeroed so stale data never leaks.
            for (int i = 0; i < 8; i++) begin
                mem_ff.memory_element[i*8 +: 8] <= strobe[i] ?
                    lane_shift(store_src(req_ff, cop_sdata),
                               req_ff.access_size_code,
                               pa_now[2:0], req_ff.big_endian,
                               1'b1)[i*8 +: 8] : 8'h00;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            load_data_ff <= '0;
            lvb_ff <= '0;
        end else if (state_ff == lsma_pkg::LSMA_ST_MEM && mem_rvalid &&
                     !mem_ff.write) begin
            lvb_ff <= mem_ff.byte_strobe;
            load_data_ff <= lane_shift(mem_rdata & {
                {8{mem_ff.byte_strobe[7]}}, {8{mem_ff.byte_strobe[6]}},
                {8{mem_ff.byte_strobe[5]}}, {8{mem_ff.byte_strobe[4]}},
                {8{mem_ff.byte_strobe[3]}}, {8{mem_ff.byte_strobe[2]}},
                {8{mem_ff.byte_strobe[1]}}, {8{mem_ff.byte_strobe[0]}}},
                req_ff.access_size_code, xl_ff.phys_addr[2:0],
                req_ff.big_endian, 1'b0);
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            exc_ff <= 1'b0;
        end else if (state_ff == lsma_pkg::LSMA_ST_XLAT && !unmapped &&
                     xlat_done) begin
            exc_ff <= !xlat_hit || !xlat_permit;
        end else if (state_ff == lsma_pkg::LSMA_ST_IDLE) begin
            exc_ff <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cop_ff <= '0;
        end else if (state_ff == lsma_pkg::LSMA_ST_IDLE && req_valid) begin
            cop_ff <= '0;
            cop_ff.unit <= req.coproc_unit;
            cop_ff.coproc_reg_select <= req.coproc_reg_select;
            cop_ff.cop_fun <= req.cop_fun;
            cop_ff.op <= req.op == lsma_pkg::LSMA_OP_COP_FN ? req.op
                       : lsma_pkg::LSMA_OP_LOAD;
        end else if (state_ff == lsma_pkg::LSMA_ST_XLAT && is_cop_st) begin
            cop_ff.op <= req_ff.op;
        end else if (state_ff == lsma_pkg::LSMA_ST_COPRD && cop_ready) begin
            cop_ff.op <= lsma_pkg::LSMA_OP_LOAD;
        end else if (state_ff == lsma_pkg::LSMA_ST_MEM && mem_rvalid &&
                     !mem_ff.write && !exc_ff) begin
            if (req_ff.op == lsma_pkg::LSMA_OP_COPROC_WORD_LOAD) begin
                cop_ff.op <= req_ff.op;
                cop_ff.data <= {32'h0, lane_shift(mem_rdata,
                    `LSMA_SZ_WORD, xl_ff.phys_addr[2:0],
                    req_ff.big_endian, 1'b0)[31:0]};
            end else if (req_ff.op == lsma_pkg::LSMA_OP_COPROC_DOUBLE_LOAD) begin
                cop_ff.op <= req_ff.op;
                cop_ff.data <= mem_rdata;
            end
        end else if (state_ff == lsma_pkg::LSMA_ST_DONE && done_valid) begin
            cop_ff.op <= lsma_pkg::LSMA_OP_LOAD;
        end
    end
endmodule : lsma_core
`default_nettype wire

//--- test/lsma_core_assertions.sv
// Port-level checker for the load/store access block.
`timescale 1ns/1ps
`default_nettype none
`include "lsma_defines.svh"
module lsma_core_checker #(
    parameter int ELEM_BYTES = 8
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire lsma_pkg::lsma_req_t req,
    input wire logic xlat_valid,
    input wire lsma_pkg::lsma_xlat_t xlat_req,
    input wire logic xlat_done,
    input wire logic xlat_hit,
    input wire logic xlat_permit,
    input wire logic mem_valid,
    input wire lsma_pkg::lsma_mem_req_t mem_req,
    input wire logic cop_valid,
    input wire lsma_pkg::lsma_cop_t cop_out,
    input wire logic done_valid,
    input wire logic exc_valid
);
    lsma_pkg::lsma_req_t cap_ff;
    logic um;
    logic st;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    function automatic logic [7:0] lanes(input logic [2:0] sz,
                                         input logic [2:0] off);
        logic [15:0] m;
        m = ((16'h1 << ({13'h0, sz} + 16'h1)) - 16'h1) << off;
        return m[7:0];
    endfunction : lanes
    function automatic logic [63:0] spread(input logic [7:0] s);
        for (int b = 0; b < 8; b++) spread[8*b+:8] = {8{s[b]}};
    endfunction : spread
    // The request is only visible at the accepting edge, so keep a copy.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cap_ff <= '0;
        end else if (req_valid && req_ready) begin
            cap_ff <= req;
        end
    end
    assign um = cap_ff.virtual_addr[31:29] inside {3'h4, 3'h5};
    assign st = cap_ff.op inside {lsma_pkg::LSMA_OP_STORE,
        lsma_pkg::LSMA_OP_COPROC_WORD_STORE, lsma_pkg::LSMA_OP_COPROC_DOUBLE_STORE};
    property p_busy;
        req_valid && req_ready |=> !req_ready;
    endproperty
    a_busy: assert property (p_busy)
        else $error("request taken while busy");
    property p_xlat_sel;
        xlat_valid |-> xlat_req.load_or_store_sel == st &&
            xlat_req.fetch_or_data_sel == cap_ff.fetch_or_data_sel;
    endproperty
    a_xlat_sel: assert property (p_xlat_sel)
        else $error("bad xlat selects");
    property p_unmap;
        xlat_valid |-> !um;
    endproperty
    a_unmap: assert property (p_unmap)
        else $error("unmapped lookup");
    property p_unmap_pa;
        mem_valid && um |-> mem_req.addr == {3'h0, cap_ff.virtual_addr[28:3],
            3'h0} && mem_req.cache_coherency_attr == (cap_ff.virtual_addr[29]
            ? `LSMA_CCA_UNCACHED : `LSMA_CCA_CACHED);
    endproperty
    a_unmap_pa: assert property (p_unmap_pa)
        else $error("bad direct map");
    property p_align;
        mem_valid |-> mem_req.addr[2:0] == 3'h0;
    endproperty
    a_align: assert property (p_align)
        else $error("unaligned element");
    property p_strobe;
        mem_valid && cap_ff.op == lsma_pkg::LSMA_OP_STORE && !cap_ff.big_endian
            |-> mem_req.byte_strobe == lanes(cap_ff.access_size_code,
            cap_ff.virtual_addr[2:0]);
    endproperty
    a_strobe: assert property (p_strobe)
        else $error("bad byte strobe");
    property p_quiet;
        mem_valid && mem_req.write |->
            (mem_req.memory_element & ~spread(mem_req.byte_strobe)) == '0;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("dirty unused lane");
    property p_exc;
        xlat_valid && xlat_done && !(xlat_hit && xlat_permit) |->
            ##[1:4] (done_valid && exc_valid);
    endproperty
    a_exc: assert property (p_exc)
        else $error("no exception");
    property p_fn;
        cop_valid && cop_out.op == lsma_pkg::LSMA_OP_COP_FN |->
            cop_out.cop_fun == cap_ff.cop_fun &&
            cop_out.unit == cap_ff.coproc_unit;
    endproperty
    a_fn: assert property (p_fn)
        else $error("bad function forward");
    c_store: cover property (mem_valid && mem_req.write);
    c_exc: cover property (done_valid && exc_valid);
    c_fn: cover property (cop_valid && cop_out.op == lsma_pkg::LSMA_OP_COP_FN);
endmodule : lsma_core_checker
bind lsma_core lsma_core_checker #(.ELEM_BYTES(ELEM_BYTES)) u_chk (
    .sys_clk, .arst_n, .req_valid, .req_ready, .req, .xlat_valid,
    .xlat_req, .xlat_done, .xlat_hit, .xlat_permit, .mem_valid, .mem_req,
    .cop_valid, .cop_out, .done_valid, .exc_valid);
`default_nettype wire

//--- test/lsma_partner.sv
// Model of translation lookup, memory and coprocessor beside the block.
`timescale 1ns/1ps
`default_nettype none
`include "lsma_defines.svh"
module lsma_partner (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic slow,
    input wire logic xlat_valid,
    input wire lsma_pkg::lsma_xlat_t xlat_req,
    output logic xlat_done,
    output logic xlat_hit,
    output logic xlat_permit,
    output logic [31:0] xlat_phys_addr,
    output logic [2:0] xlat_cca,
    input wire logic mem_valid,
    input wire lsma_pkg::lsma_mem_req_t mem_req,
    output logic mem_ready,
    output logic mem_rvalid,
    output logic cache_miss,
    output logic [63:0] mem_rdata,
    input wire logic cop_valid,
    input wire lsma_pkg::lsma_cop_t cop_out,
    output logic cop_ready,
    output logic [63:0] cop_sdata
);
    logic [63:0] mem [16];
    logic [1:0] xc, mc, cc;
    wire logic [1:0] dly = slow ? 2'h3 : 2'h0;
    wire logic [3:0] mi = mem_req.addr[6:3];
    wire logic [63:0] sd = 64'hc0de_1234_8765_4320 |
        {59'h0, cop_out.coproc_reg_select};
    // Region 1 has no entry, region 2 forbids access.
    assign xlat_hit = xlat_req.phys_addr[31:28] != 4'h1;
    assign xlat_permit = xlat_req.phys_addr[31:28] != 4'h2;
    assign xlat_phys_addr = {4'h0, xlat_req.phys_addr[27:0]};
    assign xlat_cca = `LSMA_CCA_UNCACHED;
    assign cache_miss = mem_req.cache_coherency_attr == `LSMA_CCA_CACHED;
    assign cop_sdata = cop_ready ? sd : ~sd;
    initial for (int i = 0; i < 16; i++) mem[i] = {8{i[3:0], 4'ha}};
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            {xlat_done, mem_ready, mem_rvalid, cop_ready} <= 4'h0;
            {xc, mc, cc} <= 6'h0;
            mem_rdata <= '0;
        end else begin
            {xlat_done, mem_ready, mem_rvalid, cop_ready} <= 4'h0;
            // Read data is meaningless off the answer cycle, so it churns.
            mem_rdata <= ~mem_rdata;
            xc <= (xlat_valid && !xlat_done && xc != dly) ? xc + 2'h1 : 2'h0;
            mc <= (mem_valid && !mem_ready && mc != dly) ? mc + 2'h1 : 2'h0;
            cc <= (cop_valid && !cop_ready && cc != dly) ? cc + 2'h1 : 2'h0;
            if (xlat_valid && !xlat_done && xc == dly) xlat_done <= 1'b1;
            if (cop_valid && !cop_ready && cc == dly) cop_ready <= 1'b1;
            if (mem_valid && !mem_ready && mc == dly) begin
                mem_ready <= 1'b1;
                mem_rvalid <= !mem_req.write;
                mem_rdata <= mem[mi];
                for (int b = 0; b < 8; b++) begin
                    if (mem_req.write && mem_req.byte_strobe[b]) begin
                        mem[mi][8*b+:8] <= mem_req.memory_element[8*b+:8];
                    end
                end
            end
        end
    end
endmodule : lsma_partner
`default_nettype wire

//--- test/load_store_memory_access_test.sv
// Self-checking bench for the load/store access block.
`timescale 1ns/1ps
`default_nettype none
module load_store_memory_access_test;
    localparam logic [63:0] W = 64'h8877_6655_4433_2211;
    logic sys_clk, arst_n, req_valid, slow, saw_fill, saw_xlat;
    logic req_ready, xlat_valid, xlat_done, xlat_hit, xlat_permit;
    logic mem_valid, mem_ready, mem_rvalid, cache_miss, fill_valid;
    logic cop_valid, cop_ready, done_valid, exc_valid;
    lsma_pkg::lsma_req_t req;
    lsma_pkg::lsma_xlat_t xlat_req;
    lsma_pkg::lsma_mem_req_t mem_req;
    lsma_pkg::lsma_cop_t cop_out, cop_seen;
    logic [31:0] xlat_phys_addr, fill_addr, fill_a;
    logic [2:0] xlat_cca;
    logic [63:0] mem_rdata, cop_sdata, load_data, e;
    logic [7:0] load_valid_bytes;
    int num_errors, tests_run;
    lsma_core #(.ELEM_BYTES(8)) u_dut (.sys_clk, .arst_n, .req_valid,
        .req_ready, .req, .xlat_valid, .xlat_req, .xlat_done, .xlat_hit,
        .xlat_permit, .xlat_phys_addr, .xlat_cca, .mem_valid, .mem_req,
        .mem_ready, .mem_rvalid, .cache_miss, .mem_rdata, .fill_valid,
        .fill_addr, .cop_valid, .cop_out, .cop_ready, .cop_sdata,
        .done_valid, .load_data, .load_valid_bytes, .exc_valid);
    lsma_partner u_mem (.sys_clk, .arst_n, .slow, .xlat_valid, .xlat_req,
        .xlat_done, .xlat_hit, .xlat_permit, .xlat_phys_addr, .xlat_cca,
        .mem_valid, .mem_req, .mem_ready, .mem_rvalid, .cache_miss,
        .mem_rdata, .cop_valid, .cop_out, .cop_ready, .cop_sdata);
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        if (fill_valid) begin
            saw_fill <= 1'b1;
            fill_a <= fill_addr;
        end
        if (xlat_valid) saw_xlat <= 1'b1;
    end
    // The accepted word must be visible while the answer still stands.
    always @* begin
        if (cop_valid && cop_ready) cop_seen = cop_out;
    end
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic finish_test();
        if (num_errors == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : finish_test
    task automatic run(input lsma_pkg::lsma_op_t op, input logic [31:0] va,
                       input logic [2:0] sz, input logic be);
        int n;
        @(posedge sys_clk);
        req_valid <= 1'b1;
        req <= '{op, va, sz, 1'b0, be, W, 2'h2, 5'h5, 25'h1abcde};
        n = 0;
        do begin @(negedge sys_clk); n++; end
        while (req_ready !== 1'b1 && n < 50);
        @(posedge sys_clk);
        req_valid <= 1'b0;
        n = 0;
        do begin @(negedge sys_clk); n++; end
        while (done_valid !== 1'b1 && n < 100);
        if (n >= 100) num_errors++;
    endtask : run
    task automatic t_store(input logic [2:0] sz, input logic [2:0] off,
                           input logic be);
        logic [63:0] x;
        x = u_mem.mem[8];
        for (int k = 0; k <= sz; k++) begin
            x[8*(be ? 7 - off - k : off + k)+:8] = W[8*k+:8];
        end
        run(lsma_pkg::LSMA_OP_STORE, {29'h1400_0008, off}, sz, be);
        check(u_mem.mem[8], x);
    endtask : t_store
    initial begin
        #(100 * 4000);
        num_errors++;
        finish_test();
    end
    initial begin
        {arst_n, req_valid, slow, saw_fill, saw_xlat} = 5'h0;
        req = '0;
        num_errors = 0;
        tests_run = 0;
        repeat (8) @(posedge sys_clk);
        arst_n <= 1'b1;
        @(negedge sys_clk);
        check(64'(req_ready), 64'h1);
        t_store(3'h0, 3'h5, 1'b0);
        t_store(3'h1, 3'h2, 1'b0);
        t_store(3'h3, 3'h4, 1'b0);
        t_store(3'h7, 3'h0, 1'b0);
        t_store(3'h0, 3'h1, 1'b1);
        slow <= 1'b1;
        run(lsma_pkg::LSMA_OP_LOAD, 32'ha000_0042, 3'h1, 1'b0);
        check(64'(load_valid_bytes), 64'h0c);
        run(lsma_pkg::LSMA_OP_LOAD, 32'h8000_004c, 3'h3, 1'b0);
        check(64'({saw_fill, fill_a}), 64'h1_0000_0048);
        run(lsma_pkg::LSMA_OP_LOAD, 32'h0000_0100, 3'h3, 1'b0);
        check(64'({saw_xlat, exc_valid}), 64'h2);
        run(lsma_pkg::LSMA_OP_LOAD, 32'h1000_0000, 3'h3, 1'b0);
        check(64'(exc_valid), 64'h1);
        e = u_mem.mem[1];
        run(lsma_pkg::LSMA_OP_STORE, 32'h2000_0008, 3'h7, 1'b0);
        check({e[62:0], exc_valid}, {u_mem.mem[1][62:0], 1'b1});
        slow <= 1'b0;
        run(lsma_pkg::LSMA_OP_COP_FN, 32'h0, 3'h0, 1'b0);
        check(64'({cop_seen.unit, cop_seen.cop_fun}), 64'h41a_bcde);
        run(lsma_pkg::LSMA_OP_COPROC_WORD_LOAD, 32'ha000_0048, 3'h3, 1'b0);
        check({cop_seen.coproc_reg_select, cop_seen.data[31:0]},
              {5'h5, u_mem.mem[9][31:0]});
        run(lsma_pkg::LSMA_OP_COPROC_DOUBLE_LOAD, 32'ha000_0050, 3'h7, 1'b0);
        check(cop_seen.data, u_mem.mem[10]);
        run(lsma_pkg::LSMA_OP_COPROC_WORD_STORE, 32'ha000_0058, 3'h3, 1'b0);
        check(64'(u_mem.mem[11][31:0]), 64'h8765_4325);
        run(lsma_pkg::LSMA_OP_COPROC_DOUBLE_STORE, 32'ha000_0060, 3'h7, 1'b0);
        check(u_mem.mem[12], 64'hc0de_1234_8765_4325);
        finish_test();
    end
endmodule : load_store_memory_access_test
`default_nettype wire
